/* File: hw/uitd_pkg.sv */
// Shared constants and state types for the serial interrupt and error block.
`default_nettype none

package uitd_pkg;

    // Frame shape and oversampling.
    localparam int unsigned DATA_BITS  = 8;
    localparam int unsigned OVERSAMPLE = 16;
    localparam logic [3:0]  TICK_LAST  = 4'h000F;
    localparam logic [3:0]  TICK_MID   = 4'h0007;
    localparam logic [2:0]  BIT_LAST   = 3'h0007;

    // Reset values of the line and the buffer words.
    localparam logic        LINE_IDLE  = 1'b1;
    localparam logic [7:0]  WORD_RESET = 8'h0000;

    // One-hot frame states shared by the transmitter and the receiver.
    typedef enum logic [3:0] {
        UITD_IDLE  = 4'h0001,
        UITD_START = 4'h0002,
        UITD_DATA  = 4'h0004,
        UITD_STOP  = 4'h0008
    } uitd_state_t;

endpackage : uitd_pkg

`default_nettype wire

/* File: hw/uitd_rx_frame.sv */
// Receive deserialiser that reports frame completion and stop bit checks.
`timescale 1ns/1ps
`default_nettype none

module uitd_rx_frame (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Timing and configuration.
    input  wire logic       sample_tick,
    input  wire logic       two_stop_bits,
    // Synchronised line.
    input  wire logic       rxd_sync,
    // Frame results.
    output logic            frame_done,
    output logic [7:0]      frame_word,
    output logic            frame_stop_ok,
    output logic            pre_last_stop
);

    uitd_pkg::uitd_state_t  state;
    logic [3:0]             tick_cnt;
    logic [2:0]             bit_cnt;
    logic                   stop_idx;
    logic                   stop_bad;
    logic [7:0]             shift;

    // Frame walk: middle of start bit, then one sample per bit period.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state         <= uitd_pkg::UITD_IDLE;
            tick_cnt      <= 4'h0000;
            bit_cnt       <= 3'h0000;
            stop_idx      <= 1'b0;
            stop_bad      <= 1'b0;
            shift         <= uitd_pkg::WORD_RESET;
            frame_done    <= 1'b0;
            frame_word    <= uitd_pkg::WORD_RESET;
            frame_stop_ok <= 1'b0;
            pre_last_stop <= 1'b0;
        end else begin
            frame_done    <= 1'b0;
            pre_last_stop <= 1'b0;
            if (sample_tick) begin
                tick_cnt <= tick_cnt + 4'h0001;
                case (state)
                    uitd_pkg::UITD_IDLE: begin
                        tick_cnt <= 4'h0000;
                        if (!rxd_sync) begin
                            state <= uitd_pkg::UITD_START;
                        end
                    end
                    uitd_pkg::UITD_START: begin
                        if (tick_cnt == uitd_pkg::TICK_MID) begin
                            tick_cnt <= 4'h0000;
                            bit_cnt  <= 3'h0000;
                            state    <= rxd_sync ? uitd_pkg::UITD_IDLE
                                                 : uitd_pkg::UITD_DATA;
                        end
                    end
                    uitd_pkg::UITD_DATA: begin
                        if (tick_cnt == uitd_pkg::TICK_LAST) begin
                            shift   <= {rxd_sync, shift[7:1]};
                            bit_cnt <= bit_cnt + 3'h0001;
                            if (bit_cnt == uitd_pkg::BIT_LAST) begin
                                state    <= uitd_pkg::UITD_STOP;
                                stop_idx <= 1'b0;
                                stop_bad <= 1'b0;
                                // Last data bit precedes a single stop bit.
                                pre_last_stop <= !two_stop_bits;
                            end
                        end
                    end
                    uitd_pkg::UITD_STOP: begin
                        if (tick_cnt == uitd_pkg::TICK_LAST) begin
                            if (two_stop_bits && !stop_idx) begin
                                stop_idx      <= 1'b1;
                                stop_bad      <= !rxd_sync;
                                pre_last_stop <= 1'b1;
                            end else begin
                                state         <= uitd_pkg::UITD_IDLE;
                                frame_done    <= 1'b1;
                                frame_word    <= shift;
                                frame_stop_ok <= ~stop_bad & rxd_sync;
                            end
                        end
                    end
                    default: begin
                        state <= uitd_pkg::UITD_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // uitd_rx_frame

`default_nettype wire

/* File: hw/uitd_top.sv */
// Serial channel with transmit/receive interrupt timing and error flags.
//
// How it works
// - With the source select high, the transmit interrupt pulses once the last stop bit has fully left the line.
// - With the source select low, the transmit interrupt pulses when the buffer word is loaded into the shifter.
// - The receive interrupt pulses when a finished word is moved into the receive buffer.
// - Overrun is flagged when the bit before the last stop bit of a new frame arrives while the buffer is unread.
// - A framing error is flagged when a word moved into the receive buffer had any configured stop bit sampled low.
`timescale 1ns/1ps
`default_nettype none

module uitd_top (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Timing and configuration.
    input  wire logic       sample_tick,
    input  wire logic       two_stop_bits,
    input  wire logic       tx_irq_source_select,
    // Transmit buffer side.
    input  wire logic       tx_wr,
    input  wire logic [7:0] tx_data,
    output logic            tx_empty,
    // Receive buffer side.
    input  wire logic       rx_rd,
    output logic [7:0]      rx_buffer_reg,
    output logic            rx_full,
    // Error flags.
    input  wire logic       err_clear,
    output logic            overrun_err,
    output logic            framing_err,
    // Interrupt requests.
    output logic            tx_irq,
    output logic            rx_irq,
    // Serial line.
    input  wire logic       rxd,
    output logic            txd
);

    logic                   rxd_meta;
    logic                   rxd_sync;
    logic [7:0]             tx_buffer_reg;
    logic [7:0]             tx_shift;
    uitd_pkg::uitd_state_t  tx_state;
    logic [3:0]             tx_tick;
    logic [2:0]             tx_bit;
    logic                   tx_stop_idx;
    logic                   tx_load;
    logic                   tx_done;
    logic                   frame_done;
    logic [7:0]             frame_word;
    logic                   frame_stop_ok;
    logic                   pre_last_stop;
    logic                   rx_accept;

    // Two-stage synchroniser for the incoming line.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxd_meta <= uitd_pkg::LINE_IDLE;
            rxd_sync <= uitd_pkg::LINE_IDLE;
        end else begin
            rxd_meta <= rxd;
            rxd_sync <= rxd_meta;
        end
    end

    // Load happens as soon as the shifter is idle and a word waits.
    assign tx_load = (tx_state == uitd_pkg::UITD_IDLE) && !tx_empty;
    // End of the final stop bit period.
    assign tx_done = (tx_state == uitd_pkg::UITD_STOP) && sample_tick
                   && (tx_tick == uitd_pkg::TICK_LAST)
                   && (!two_stop_bits || tx_stop_idx);

    // Transmit buffer: a write during a load keeps the new word pending.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_buffer_reg <= uitd_pkg::WORD_RESET;
            tx_empty      <= 1'b1;
        end else if (tx_wr) begin
            tx_buffer_reg <= tx_data;
            tx_empty      <= 1'b0;
        end else if (tx_load) begin
            tx_empty      <= 1'b1;
        end
    end

    // Transmit shifter: start bit, eight data bits LSB first, stop bits.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state    <= uitd_pkg::UITD_IDLE;
            tx_shift    <= uitd_pkg::WORD_RESET;
            tx_tick     <= 4'h0000;
            tx_bit      <= 3'h0000;
            tx_stop_idx <= 1'b0;
            txd         <= uitd_pkg::LINE_IDLE;
        end else begin
            case (tx_state)
                uitd_pkg::UITD_IDLE: begin
                    txd     <= uitd_pkg::LINE_IDLE;
                    tx_tick <= 4'h0000;
                    if (tx_load) begin
                        tx_shift <= tx_buffer_reg;
                        tx_state <= uitd_pkg::UITD_START;
                        txd      <= 1'b0;
                    end
                end
                uitd_pkg::UITD_START: begin
                    if (sample_tick) begin
                        tx_tick <= tx_tick + 4'h0001;
                        if (tx_tick == uitd_pkg::TICK_LAST) begin
                            tx_state <= uitd_pkg::UITD_DATA;
                            tx_bit   <= 3'h0000;
                            txd      <= tx_shift[0];
                        end
                    end
                end
                uitd_pkg::UITD_DATA: begin
                    if (sample_tick) begin
                        tx_tick <= tx_tick + 4'h0001;
                        if (tx_tick == uitd_pkg::TICK_LAST) begin
                            tx_bit   <= tx_bit + 3'h0001;
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            txd      <= tx_shift[1];
                            if (tx_bit == uitd_pkg::BIT_LAST) begin
                                tx_state    <= uitd_pkg::UITD_STOP;
                                tx_stop_idx <= 1'b0;
                                txd         <= uitd_pkg::LINE_IDLE;
                            end
                        end
                    end
                end
                uitd_pkg::UITD_STOP: begin
                    if (sample_tick) begin
                        tx_tick <= tx_tick + 4'h0001;
                        if (tx_tick == uitd_pkg::TICK_LAST) begin
                            tx_stop_idx <= 1'b1;
                        end
                    end
                    if (tx_done) begin
                        tx_state <= uitd_pkg::UITD_IDLE;
                    end
                end
                default: begin
                    tx_state <= uitd_pkg::UITD_IDLE;
                end
            endcase
        end
    end

    // Transmit interrupt source chosen by the select input.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_irq <= 1'b0;
        end else begin
            tx_irq <= tx_irq_source_select ? tx_done
                                           : tx_load;
        end
    end

    // Frame receiver.
    uitd_rx_frame u_rx (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .sample_tick   (sample_tick),
        .two_stop_bits (two_stop_bits),
        .rxd_sync      (rxd_sync),
        .frame_done    (frame_done),
        .frame_word    (frame_word),
        .frame_stop_ok (frame_stop_ok),
        .pre_last_stop (pre_last_stop)
    );

    // A finished word enters the buffer only if it is free or read now.
    assign rx_accept = frame_done && (!rx_full || rx_rd);

    // Receive buffer, its full flag and the receive interrupt.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_buffer_reg <= uitd_pkg::WORD_RESET;
            rx_full       <= 1'b0;
            rx_irq        <= 1'b0;
            framing_err   <= 1'b0;
        end else begin
            rx_irq <= rx_accept;
            if (rx_accept) begin
                rx_buffer_reg <= frame_word;
                rx_full       <= 1'b1;
                framing_err   <= !frame_stop_ok;
            end else if (rx_rd) begin
                rx_full <= 1'b0;
            end
        end
    end

    // Sticky overrun flag; a new overrun beats a clear in the same cycle.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_err <= 1'b0;
        end else if (pre_last_stop && rx_full && !rx_rd) begin
            overrun_err <= 1'b1;
        end else if (err_clear) begin
            overrun_err <= 1'b0;
        end
    end

    // Checks on the interrupt and error timing.
    a_tx_irq_done: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (tx_done && tx_irq_source_select) |=> tx_irq)
        else $error("transmit end did not raise the interrupt");
    a_tx_irq_load: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (tx_load && !tx_irq_source_select)
        |=> (tx_irq && tx_state == uitd_pkg::UITD_START))
        else $error("buffer load did not raise the interrupt");
    a_tx_irq_cause: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        tx_irq |-> ($past(tx_irq_source_select) ? $past(tx_done)
                                                : $past(tx_load)))
        else $error("transmit interrupt without its cause");
    a_rx_irq_word: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        rx_accept |=> (rx_irq && rx_full
                       && rx_buffer_reg == $past(frame_word)))
        else $error("accepted word not in buffer with interrupt");
    // A clear may follow one cycle later, so only the set itself is checked.
    a_overrun_set: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (pre_last_stop && rx_full && !rx_rd) |=> overrun_err)
        else $error("overrun not flagged");
    a_framing_bad: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (rx_accept && !frame_stop_ok) |=> framing_err)
        else $error("framing error not flagged");
    a_read_frees: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (rx_rd && !frame_done) |=> (!rx_full && !$rose(overrun_err)))
        else $error("read did not free the buffer");

endmodule // uitd_top

`default_nettype wire

/* File: dv/uitd_remote.sv */
// Remote serial device model that sends frames and captures line words.
`timescale 1ns/1ps
`default_nettype none

module uitd_remote (
    // Clock and oversample strobe.
    input  wire logic sys_clk,
    input  wire logic sample_tick,
    // Serial line.
    input  wire logic txd,
    output logic      rxd
);
    // The line idles high between frames, as the protocol requires.
    initial rxd = 1'b1;

    // Waits a number of oversample strobes, then steps to a falling edge.
    task automatic ticks(input int n);
        repeat (n) begin
            do @(posedge sys_clk); while (sample_tick !== 1'b1);
        end
        @(negedge sys_clk);
    endtask

    // Sends one frame LSB first; bad drives the last stop bit low.
    task automatic send(input logic [7:0] w, input logic two, bad);
        rxd = 1'b0;
        ticks(16);
        for (int i = 0; i < 8; i++) begin
            rxd = w[i];
            ticks(16);
        end
        rxd = two ? 1'b1 : ~bad;
        ticks(16);
        if (two) begin
            rxd = ~bad;
            ticks(16);
        end
        rxd = 1'b1;
        // Idle one bit period so a low stop bit cannot run into the next start.
        ticks(16);
    endtask

    // Captures one word from the line, sampling each bit at its middle.
    task automatic catch_word(output logic [7:0] w);
        int n;
        n = 0;
        w = 8'h00;
        while (txd !== 1'b0 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        ticks(8);
        for (int i = 0; i < 8; i++) begin
            ticks(16);
            w[i] = txd;
        end
    endtask
endmodule // uitd_remote

`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the serial interrupt and error block.
`timescale 1ns/1ps
`default_nettype none

// Compares one value and counts the comparison.
`define CHK(nm, ex, got) \
    begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end

module tb_top;
    // Design connections.
    logic       sys_clk, reset_n, sample_tick, two_stop_bits;
    logic       tx_irq_source_select, tx_wr, rx_rd, err_clear, rxd;
    logic [7:0] tx_data, rx_buffer_reg;
    logic       tx_empty, rx_full, overrun_err, framing_err;
    logic       tx_irq, rx_irq, txd;
    // Bench state.
    int         error_cnt, n_checks;
    logic [1:0] tick_div;
    logic       done;

    uitd_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .sample_tick(sample_tick), .two_stop_bits(two_stop_bits),
        .tx_irq_source_select(tx_irq_source_select), .tx_wr(tx_wr),
        .tx_data(tx_data), .tx_empty(tx_empty), .rx_rd(rx_rd),
        .rx_buffer_reg(rx_buffer_reg), .rx_full(rx_full),
        .err_clear(err_clear), .overrun_err(overrun_err),
        .framing_err(framing_err), .tx_irq(tx_irq), .rx_irq(rx_irq),
        .rxd(rxd), .txd(txd));

    uitd_remote u_far (.sys_clk(sys_clk), .sample_tick(sample_tick),
        .txd(txd), .rxd(rxd));

    // Clock of 50 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // One oversample strobe every four cycles, driven on the falling edge.
    always @(negedge sys_clk) begin
        tick_div    <= tick_div + 2'h1;
        sample_tick <= (tick_div == 2'h3);
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Pulses the read strobe and the error clear for one cycle.
    task automatic pulse(input logic rd, clr);
        rx_rd     = rd;
        err_clear = clr;
        @(negedge sys_clk);
        rx_rd     = 1'b0;
        err_clear = 1'b0;
        @(negedge sys_clk);
    endtask

    // Receives one frame from the far side and notes any receive interrupt.
    task automatic rx_frame(input logic [7:0] w, input logic two, bad,
                            output logic seen);
        seen = 1'b0;
        done = 1'b0;
        fork
            begin
                u_far.send(w, two, bad);
                @(negedge sys_clk);
                done = 1'b1;
            end
            while (!done) begin
                @(negedge sys_clk);
                if (rx_irq === 1'b1) seen = 1'b1;
            end
        join
    endtask

    // Transmit interrupt timing: load source, end source with one and two stops.
    task automatic test_tx();
        int         cyc;
        int         lo;
        logic [7:0] got;
        for (int s = 0; s < 3; s++) begin
            tx_irq_source_select = (s != 0);
            two_stop_bits = (s == 2);
            // Frame ticks at four cycles each; first tick lands 1 to 4 late.
            lo      = 4 * 16 * (10 + (s == 2)) - 1;
            tx_data = 8'h96 ^ s[7:0];
            tx_wr   = 1'b1;
            @(negedge sys_clk);
            tx_wr = 1'b0;
            cyc   = 1;
            `CHK("tx_empty_wr", 1'b0, tx_empty)
            fork
                while (tx_irq !== 1'b1 && cyc < 1500) begin
                    @(negedge sys_clk);
                    cyc++;
                end
                u_far.catch_word(got);
            join
            if (cyc >= 1500) begin
                error_cnt++;
                $display("mismatch tx_irq exp pulse got timeout");
                close_out();
            end
            `CHK("tx_word", 8'h96 ^ s[7:0], got)
            if (s == 0) `CHK("tx_irq_load", 1'b1, cyc == 2)
            else `CHK("tx_irq_end", 1'b1, cyc >= lo && cyc < lo + 4)
            repeat (200) @(negedge sys_clk);
            `CHK("txd_idle", 1'b1, txd)
            `CHK("tx_empty_end", 1'b1, tx_empty)
        end
        two_stop_bits = 1'b0;
        $display("test tx done");
    endtask

    // Good frames, stop bit faults and reads with one and two stop bits.
    task automatic test_rx();
        logic seen;
        for (int t = 0; t < 2; t++) begin
            two_stop_bits = t[0];
            for (int b = 0; b < 2; b++) begin
                rx_frame(8'hA5 ^ t[7:0], t[0], b[0], seen);
                `CHK("rx_irq", 1'b1, seen)
                `CHK("rx_word", 8'hA5 ^ t[7:0], rx_buffer_reg)
                `CHK("rx_full", 1'b1, rx_full)
                `CHK("framing_err", b[0], framing_err)
                pulse(1'b1, 1'b0);
                `CHK("rx_full_read", 1'b0, rx_full)
                `CHK("overrun_none", 1'b0, overrun_err)
            end
        end
        $display("test rx done");
    endtask

    // Overrun on an unread buffer, clear, then a read that prevents it,
    // with one and then two stop bits.
    task automatic test_overrun();
        logic seen;
        for (int t = 0; t < 2; t++) begin
            two_stop_bits = t[0];
            rx_frame(8'h3C, t[0], 1'b0, seen);
            rx_frame(8'hC3, t[0], 1'b0, seen);
            `CHK("overrun_set", 1'b1, overrun_err)
            `CHK("drop_irq", 1'b0, seen)
            `CHK("drop_word", 8'h3C, rx_buffer_reg)
            pulse(1'b0, 1'b1);
            `CHK("overrun_clear", 1'b0, overrun_err)
            pulse(1'b1, 1'b0);
            rx_frame(8'h5A, t[0], 1'b0, seen);
            `CHK("no_overrun", 1'b0, overrun_err)
            `CHK("after_read_irq", 1'b1, seen)
            `CHK("after_read_word", 8'h5A, rx_buffer_reg)
            pulse(1'b1, 1'b0);
        end
        $display("test overrun done");
    endtask

    // Main sequence: reset for 12 cycles, then each scenario in turn.
    initial begin
        error_cnt = 0;
        n_checks  = 0;
        tick_div  = 2'h0;
        sample_tick = 1'b0;
        reset_n = 1'b0;
        two_stop_bits = 1'b0;
        tx_irq_source_select = 1'b0;
        tx_wr = 1'b0;
        tx_data = 8'h00;
        rx_rd = 1'b0;
        err_clear = 1'b0;
        done = 1'b0;
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        test_tx();
        test_rx();
        test_overrun();
        close_out();
    end
endmodule // tb_top

`default_nettype wire
